// ===== bench/spp_engine_chk.sv
`timescale 1ns/100ps
// Port checker for the engine; bound from the bench top.
module spp_engine_chk
  import spp_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Transmit side.
  input wire logic [7:0] tx_data_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  // Settings.
  input wire logic print_mode_in,
  input wire logic [7:0] print_code_high_in,
  input wire logic [7:0] print_code_low_in,
  input wire logic [13:0] serial_timer_ms_in,
  input wire logic menu_active_in,
  input wire logic enter_short_press_in,
  // Register read port.
  input wire logic [7:0] reg_code_high_char_out,
  input wire logic [7:0] reg_code_low_char_out,
  input wire logic reg_read_out
);
  default clocking @(posedge ref_clk_in); endclocking
  // A stalled character must stay put, or the reply loses a byte.
  a_tx_held: assert property (disable iff (!arst_n_in)
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("stalled tx character changed");
  // Reset silences both request outputs.
  a_reset_quiet: assert property (!arst_n_in |-> !tx_valid_out && !reg_read_out)
    else $error("output active in reset");
  // One read per request, and the code holds while the value is sampled.
  a_read_single: assert property (disable iff (!arst_n_in)
    reg_read_out |=> !reg_read_out && $stable(reg_code_high_char_out))
    else $error("read pulse too long or code moved");
  a_print_code: assert property (disable iff (!arst_n_in)
    print_mode_in && reg_read_out |-> reg_code_high_char_out == print_code_high_in
      && reg_code_low_char_out == print_code_low_in)
    else $error("print read used wrong code");
  // Periods under the minimum never start lines.
  a_short_timer: assert property (disable iff (!arst_n_in)
    print_mode_in && serial_timer_ms_in inside {[14'h0001:14'h0009]}
      && !enter_short_press_in |-> !reg_read_out)
    else $error("line started with short timer");
  a_menu_holds: assert property (disable iff (!arst_n_in)
    print_mode_in && menu_active_in && serial_timer_ms_in != 14'h0000
      && !enter_short_press_in |-> !reg_read_out)
    else $error("line started inside menu");
  a_manual_line: assert property (disable iff (!arst_n_in)
    print_mode_in && serial_timer_ms_in == 14'h0000 && $rose(enter_short_press_in)
      |-> ##[1:40] reg_read_out)
    else $error("key press gave no line");
  a_code_steady: assert property (disable iff (!arst_n_in)
    reg_read_out |=> $stable(reg_code_low_char_out))
    else $error("low code moved during read");
  c_poll: cover property (reg_read_out && !print_mode_in);
  c_print: cover property (reg_read_out && print_mode_in);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule

// ===== bench/spp_host_model.sv
`timescale 1ns/100ps
// Host on the link: frames requests and collects what the engine sends.
module spp_host_model
  import spp_pkg::*;
(
  // Clock.
  input wire logic clk_in,
  // High makes the host take characters only now and then.
  input wire logic slow_in,
  // High stops the host taking characters at all.
  input wire logic hold_in,
  // Towards the engine.
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  // From the engine.
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  int seed = 1;
  logic [7:0] got_q[$];
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // One character then a gap; the idle data line is inverted so it carries no stale value.
  task automatic send_char(input logic [7:0] c);
    @(posedge clk_in);
    rx_data_out <= c;
    rx_valid_out <= 1'b1;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~c;
  endtask
  // Start mark, address high then low, code high then low, end mark.
  task automatic send_frame(input logic [7:0] a1, a2, c1, c2, last);
    logic [7:0] f[6];
    f = '{CH_EOT, a1, a2, c1, c2, last};
    foreach (f[i]) send_char(f[i]);
  endtask
  // Take characters; when slow, ready is low about two cycles in three.
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
    tx_ready_out <= !hold_in && (!slow_in || ($random(seed) % 3 == 0));
  end
endmodule

// ===== bench/spp_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module serial_poll_and_print_port_test
  import spp_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic arst_n_in;
  logic [7:0] rxd, txd, pch = 8'h3A, pcl = 8'h31, rch, rcl, adr_h = 8'h31, adr_l = 8'h31;
  logic rxv, txv, txr, pm = 1'b0, cf = 1'b0, menu = 1'b0, ent = 1'b0, rrd;
  logic neg = 1'b0, known = 1'b1, slow = 1'b0, hold = 1'b0;
  logic [13:0] tmr = 14'h0000;
  logic [19:0] mag = 20'h00000;
  int seed = 1;
  int failures = 0;
  int compares = 0;
  int exp_q[$];
  always #25 ref_clk_in = ~ref_clk_in;
  spp_engine dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .rx_data_in(rxd),
    .rx_valid_in(rxv), .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(txr),
    .print_mode_in(pm), .compact_format_in(cf), .address_high_char_in(adr_h),
    .address_low_char_in(adr_l), .print_code_high_in(pch), .print_code_low_in(pcl),
    .serial_timer_ms_in(tmr), .menu_active_in(menu), .enter_short_press_in(ent),
    .reg_code_high_char_out(rch), .reg_code_low_char_out(rcl), .reg_read_out(rrd),
    .reg_magnitude_in(mag), .reg_negative_in(neg), .reg_known_in(known));
  spp_host_model host (.clk_in(ref_clk_in), .slow_in(slow), .hold_in(hold),
    .rx_data_out(rxd), .rx_valid_out(rxv), .tx_data_in(txd), .tx_valid_in(txv),
    .tx_ready_out(txr));
  // Ends the run with the counts and the verdict.
  task print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Decimal digits, padded to six or with leading zeros dropped.
  task automatic put_num(input int v, input bit pad);
    int a;
    bit s;
    a = v < 0 ? -v : v;
    s = pad;
    for (int p = 100000; p > 0; p /= 10) begin
      if (s || a / p % 10 != 0 || p == 1) begin
        exp_q.push_back(48 + a / p % 10);
        s = 1;
      end
    end
  endtask
  // Waits a bounded time for the expected count, then compares every character.
  task automatic check_out(input string nm);
    int n;
    n = 0;
    while (host.got_q.size() < exp_q.size() && n < 4000) begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (80) @(posedge ref_clk_in);
    if (n == 4000) begin
      failures++;
      print_verdict();
    end
    `CHK(nm, exp_q.size(), host.got_q.size())
    for (int i = 0; i < exp_q.size() && i < host.got_q.size(); i++)
      `CHK(nm, 8'(exp_q[i]), host.got_q[i])
    host.got_q = {};
    exp_q = {};
    $display("test %s done", nm);
  endtask
  // One host request with the register source set up for it.
  task automatic do_poll(input logic [7:0] c, input int v, input bit k, input string nm);
    int b;
    int s;
    @(posedge ref_clk_in);
    mag <= 20'(v < 0 ? -v : v);
    neg <= (v < 0);
    known <= k;
    host.send_frame(adr_h, adr_l, CH_COLON, c, CH_ENQ);
    s = exp_q.size();
    exp_q.push_back(2);
    exp_q.push_back(58);
    exp_q.push_back(c);
    if (!k) exp_q.push_back(4);
    else begin
      if (v < 0) exp_q.push_back(45);
      put_num(v, 0);
      exp_q.push_back(3);
      b = 0;
      for (int i = s + 1; i < exp_q.size(); i++) b ^= exp_q[i];
      exp_q.push_back(b);
    end
    // While the host is held, replies pile up and are checked together later.
    if (!hold) check_out(nm);
  endtask
  // Main sequence.
  initial begin
    logic [7:0] codes[6];
    arst_n_in <= 1'b0;
    codes = '{8'h31, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
    repeat (8) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    do_poll(8'h31, -180, 1, "example");
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      do_poll(codes[i], $random(seed) % 1000000, 1, "codes");
    end
    do_poll(8'h31, 0, 1, "zero");
    adr_h <= 8'h34;
    adr_l <= 8'h32;
    do_poll(8'h31, -999999, 1, "max");
    adr_h <= 8'h31;
    adr_l <= 8'h31;
    do_poll(8'h39, 5, 0, "unknown");
    host.send_frame(8'h31, 8'h31, CH_COLON, 8'h31, 8'h06);
    exp_q = {8'h15};
    check_out("nak");
    host.send_frame(8'h31, 8'h32, CH_COLON, 8'h31, CH_ENQ);
    exp_q = {};
    check_out("addr");
    // Reset in mid-run while idle; the engine must come back ready for what follows.
    arst_n_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    pm <= 1'b1;
    host.send_frame(8'h31, 8'h31, CH_COLON, 8'h31, CH_ENQ);
    check_out("ignored");
    for (int c = 0; c < 2; c++) begin
      cf <= c[0];
      pcl <= c[0] ? 8'h36 : 8'h31;
      ent <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      ent <= 1'b0;
      exp_q = {};
      if (c == 0) exp_q.push_back(32);
      exp_q.push_back(neg ? 45 : 43);
      put_num(mag, 1);
      if (c == 0) exp_q.push_back(10);
      exp_q.push_back(13);
      check_out("print");
    end
    tmr <= 14'h0005;
    repeat (50) @(posedge ref_clk_in);
    menu <= 1'b1;
    tmr <= 14'h0064;
    repeat (50) @(posedge ref_clk_in);
    menu <= 1'b0;
    tmr <= 14'h0000;
    pm <= 1'b0;
    check_out("quiet");
    // Host stops taking characters: two replies (19 characters) overflow the 17 places of
    // the buffer and its output stage, so the emitter must stall without losing any.
    hold <= 1'b1;
    do_poll(8'h33, 123456, 1, "stall");
    repeat (60) @(posedge ref_clk_in);
    do_poll(8'h34, -42, 1, "stall");
    repeat (60) @(posedge ref_clk_in);
    `CHK("stall none", 0, host.got_q.size())
    `CHK("stall valid", 1'b1, txv)
    `CHK("stall code", {CH_COLON, 8'h34}, {rch, rcl})
    hold <= 1'b0;
    check_out("stall");
    print_verdict();
  end
endmodule
bind spp_engine spp_engine_chk chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .print_mode_in(print_mode_in), .print_code_high_in(print_code_high_in),
  .print_code_low_in(print_code_low_in), .serial_timer_ms_in(serial_timer_ms_in),
  .menu_active_in(menu_active_in), .enter_short_press_in(enter_short_press_in),
  .reg_code_high_char_out(reg_code_high_char_out),
  .reg_code_low_char_out(reg_code_low_char_out), .reg_read_out(reg_read_out));

// ===== logic/spp_engine.sv
`timescale 1ns/100ps
// Serial poll and print engine: parses host requests, builds replies and print lines.
module spp_engine
  import spp_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Received characters from the UART, one-cycle valid.
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  // Transmit characters to the UART.
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  // Configuration settings.
  input wire logic print_mode_in,
  input wire logic compact_format_in,
  input wire logic [7:0] address_high_char_in,
  input wire logic [7:0] address_low_char_in,
  input wire logic [7:0] print_code_high_in,
  input wire logic [7:0] print_code_low_in,
  input wire logic [13:0] serial_timer_ms_in,
  input wire logic menu_active_in,
  input wire logic enter_short_press_in,
  // Register read port: value as sign and magnitude, sampled in the read-pulse cycle.
  output logic [7:0] reg_code_high_char_out,
  output logic [7:0] reg_code_low_char_out,
  output logic reg_read_out,
  input wire logic [19:0] reg_magnitude_in,
  input wire logic reg_negative_in,
  input wire logic reg_known_in
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR_H, ST_ADDR_L, ST_CODE_H, ST_CODE_L, ST_ENQ,
    ST_FETCH, ST_CONVERT, ST_EMIT
  } spp_state_type;

  typedef enum logic [3:0] {
    EM_STX, EM_CODE_H, EM_CODE_L, EM_SPACE, EM_SIGN, EM_DIGIT,
    EM_ETX, EM_BCC, EM_LF, EM_CR, EM_EOT, EM_NAK, EM_DONE
  } spp_emit_type;

  typedef struct packed {
    spp_state_type st;
    spp_emit_type em;
    logic print;
    logic addr_ok;
    logic [7:0] code_h;
    logic [7:0] code_l;
    logic [19:0] value;
    logic neg;
    logic known;
    logic [NUM_DIGITS-1:0][3:0] dig;
    logic [2:0] didx;
    logic [4:0] conv;
    logic started;
    logic [7:0] bcc;
    logic [15:0] tick;
    logic [13:0] ms;
    logic pend;
    logic rd;
    logic [7:0] ch;
    logic ch_v;
    logic rxv1;
    logic rxv2;
    logic key1;
    logic key2;
    logic key3;
  } spp_state_struct_type;

  spp_state_struct_type s_r;
  spp_state_struct_type s_nxt;
  logic fifo_ready;
  logic [7:0] rx_q1_r;
  logic [7:0] rx_q2_r;

  spp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .wr_data_in(s_r.ch),
    .wr_valid_in(s_r.ch_v),
    .wr_ready_out(fifo_ready),
    .rd_data_out(tx_data_out),
    .rd_valid_out(tx_valid_out),
    .rd_ready_in(tx_ready_in)
  );

  // Received data ride beside the synchronised strobe so both arrive together.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_q1_r <= 8'h00;
      rx_q2_r <= 8'h00;
    end else begin
      rx_q1_r <= rx_data_in;
      rx_q2_r <= rx_q1_r;
    end
  end

  assign reg_code_high_char_out = s_r.code_h;
  assign reg_code_low_char_out = s_r.code_l;
  assign reg_read_out = s_r.rd;

  // All next-state logic lives in one process.
  always_comb begin
    logic [7:0] c;
    logic rx_ev;
    logic key_ev;
    logic fire;
    c = rx_q2_r;
    rx_ev = s_r.rxv2;
    key_ev = s_r.key2 && !s_r.key3;
    fire = 1'b0;
    s_nxt = s_r;
    s_nxt.rxv1 = rx_valid_in;
    s_nxt.rxv2 = s_r.rxv1;
    s_nxt.key1 = enter_short_press_in;
    s_nxt.key2 = s_r.key1;
    s_nxt.key3 = s_r.key2;
    s_nxt.rd = 1'b0;
    s_nxt.ch_v = 1'b0;

    // Serial timer in 1 ms steps; it is cleared and held at zero while the menu is open.
    if (!print_mode_in || menu_active_in || serial_timer_ms_in < TIMER_MIN_MS) begin
      s_nxt.tick = 16'h0000;
      s_nxt.ms = 14'h0000;
    end else if (s_r.tick == TICK_CYCLES - 16'h0001) begin
      s_nxt.tick = 16'h0000;
      if (s_r.ms >= serial_timer_ms_in - 14'h0001) begin
        s_nxt.ms = 14'h0000;
        fire = 1'b1;
      end else begin
        s_nxt.ms = s_r.ms + 14'h0001;
      end
    end else begin
      s_nxt.tick = s_r.tick + 16'h0001;
    end
    if (print_mode_in && !menu_active_in && serial_timer_ms_in == 14'h0000 && key_ev) begin
      fire = 1'b1;
    end
    if (fire) begin
      s_nxt.pend = 1'b1;
    end

    unique case (s_r.st)
      ST_IDLE: begin
        if (rx_ev && c == CH_EOT && !print_mode_in) begin
          s_nxt.st = ST_ADDR_H;
        end else if (s_r.pend && print_mode_in) begin
          s_nxt.pend = fire; // A trigger landing in this cycle stays pending.
          s_nxt.print = 1'b1;
          s_nxt.code_h = print_code_high_in;
          s_nxt.code_l = print_code_low_in;
          s_nxt.rd = 1'b1;
          s_nxt.st = ST_FETCH;
        end
      end
      ST_ADDR_H: begin
        if (rx_ev) begin
          s_nxt.addr_ok = (c == address_high_char_in);
          s_nxt.st = (c == CH_EOT) ? ST_ADDR_H : ST_ADDR_L;
        end
      end
      ST_ADDR_L: begin
        if (rx_ev) begin
          s_nxt.addr_ok = s_r.addr_ok && (c == address_low_char_in);
          s_nxt.st = (c == CH_EOT) ? ST_ADDR_H : ST_CODE_H;
        end
      end
      ST_CODE_H: begin
        if (rx_ev) begin
          s_nxt.code_h = c;
          s_nxt.st = (c == CH_EOT) ? ST_ADDR_H : ST_CODE_L;
        end
      end
      ST_CODE_L: begin
        if (rx_ev) begin
          s_nxt.code_l = c;
          s_nxt.st = (c == CH_EOT) ? ST_ADDR_H : ST_ENQ;
        end
      end
      ST_ENQ: begin
        if (rx_ev) begin
          s_nxt.print = 1'b0;
          if (c == CH_EOT) begin
            s_nxt.st = ST_ADDR_H;
          end else if (!s_r.addr_ok) begin
            s_nxt.st = ST_IDLE;
          end else if (c == CH_ENQ) begin
            s_nxt.rd = 1'b1;
            s_nxt.st = ST_FETCH;
          end else begin
            s_nxt.em = EM_NAK;
            s_nxt.st = ST_EMIT;
          end
        end
      end
      ST_FETCH: begin
        // Register value is sampled in the cycle of the read pulse, at the edge that ends it.
        s_nxt.value = reg_magnitude_in;
        s_nxt.neg = reg_negative_in;
        s_nxt.known = reg_known_in;
        for (int i = 0; i < NUM_DIGITS; i++) begin
          s_nxt.dig[i] = 4'h0;
        end
        s_nxt.conv = 5'h00;
        s_nxt.st = ST_CONVERT;
      end
      ST_CONVERT: begin
        // Shift-add-3 binary to BCD, one bit per cycle; cheap and fast enough for a UART.
        for (int i = 0; i < NUM_DIGITS; i++) begin
          s_nxt.dig[i] = (s_r.dig[i] >= 4'h5) ? s_r.dig[i] + 4'h3 : s_r.dig[i];
        end
        for (int i = NUM_DIGITS - 1; i > 0; i--) begin
          s_nxt.dig[i] = {s_nxt.dig[i][2:0], s_nxt.dig[i-1][3]};
        end
        s_nxt.dig[0] = {s_nxt.dig[0][2:0], s_r.value[19]};
        s_nxt.value = {s_r.value[18:0], 1'b0};
        s_nxt.conv = s_r.conv + 5'h01;
        if (s_r.conv == 5'h13) begin
          s_nxt.st = ST_EMIT;
          s_nxt.bcc = 8'h00;
          s_nxt.started = 1'b0;
          s_nxt.didx = 3'(NUM_DIGITS - 1);
          s_nxt.em = s_r.print ? (compact_format_in ? EM_SIGN : EM_SPACE) : EM_STX;
        end
      end
      ST_EMIT: begin
        // One character every other cycle: the gap lets the full flag see the last push,
        // so no character is dropped at the full edge; half rate is ample for a UART.
        if (fifo_ready && !s_r.ch_v) begin
          s_nxt.ch_v = 1'b1;
          unique case (s_r.em)
            EM_STX: begin
              s_nxt.ch = CH_STX;
              s_nxt.em = EM_CODE_H;
            end
            EM_CODE_H: begin
              s_nxt.ch = s_r.code_h;
              s_nxt.bcc = s_r.code_h;
              s_nxt.em = EM_CODE_L;
            end
            EM_CODE_L: begin
              s_nxt.ch = s_r.code_l;
              s_nxt.bcc = s_r.bcc ^ s_r.code_l;
              s_nxt.em = s_r.known ? EM_SIGN : EM_EOT;
            end
            EM_SPACE: begin
              s_nxt.ch = CH_SPACE;
              s_nxt.em = EM_SIGN;
            end
            EM_SIGN: begin
              if (!s_r.print && !s_r.neg) begin
                s_nxt.ch_v = 1'b0; // Positive reply values carry no sign.
              end
              s_nxt.ch = s_r.neg ? CH_MINUS : CH_PLUS;
              s_nxt.bcc = s_r.bcc ^ (s_r.print ? 8'h00 : s_nxt.ch);
              if (!s_r.print && !s_r.neg) begin
                s_nxt.bcc = s_r.bcc;
              end
              s_nxt.em = EM_DIGIT;
            end
            EM_DIGIT: begin
              s_nxt.ch = CH_ZERO | {4'h0, s_r.dig[s_r.didx]};
              if (!s_r.print && !s_r.started && s_r.dig[s_r.didx] == 4'h0
                  && s_r.didx != 3'h0) begin
                s_nxt.ch_v = 1'b0;
              end else begin
                s_nxt.started = 1'b1;
                s_nxt.bcc = s_r.bcc ^ s_nxt.ch;
              end
              if (s_r.didx == 3'h0) begin
                s_nxt.em = s_r.print ? (compact_format_in ? EM_CR : EM_LF) : EM_ETX;
              end else begin
                s_nxt.didx = s_r.didx - 3'h1;
              end
            end
            EM_ETX: begin
              s_nxt.ch = CH_ETX;
              s_nxt.bcc = s_r.bcc ^ CH_ETX;
              s_nxt.em = EM_BCC;
            end
            EM_BCC: begin
              s_nxt.ch = s_r.bcc;
              s_nxt.em = EM_DONE;
            end
            EM_LF: begin
              s_nxt.ch = CH_LF;
              s_nxt.em = EM_CR;
            end
            EM_CR: begin
              s_nxt.ch = CH_CR;
              s_nxt.em = EM_DONE;
            end
            EM_EOT: begin
              s_nxt.ch = CH_EOT;
              s_nxt.em = EM_DONE;
            end
            EM_NAK: begin
              s_nxt.ch = CH_NAK;
              s_nxt.em = EM_DONE;
            end
            EM_DONE: begin
              s_nxt.ch_v = 1'b0;
              s_nxt.st = ST_IDLE;
            end
            default: begin
              s_nxt.ch_v = 1'b0;
              s_nxt.st = ST_IDLE;
            end
          endcase
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== logic/spp_fifo.sv
`timescale 1ns/100ps
// Small synchronous FIFO; read data come from a register.
module spp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Filling side.
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  // Draining side.
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [WIDTH-1:0] out_r;
  logic outv_r;
  logic do_wr;
  logic do_rd;

  // The output register is refilled whenever it is empty or being drained.
  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = (cnt_r != '0) && (!outv_r || rd_ready_in);
  assign rd_data_out = out_r;
  assign rd_valid_out = outv_r;

  // Storage has no reset; pointers, count and output stage do.
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wp_r] <= wr_data_in;
    end
  end

  // Pointer, count and output stage.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      out_r <= '0;
      outv_r <= 1'b0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= rp_r + 1'b1;
        out_r <= mem[rp_r];
        outv_r <= 1'b1;
      end else if (rd_ready_in) begin
        outv_r <= 1'b0;
      end
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ===== logic/spp_pkg.sv
package spp_pkg;
  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_COLON = 8'h3A;
  // Number of decimal digits in a formatted value.
  localparam int NUM_DIGITS = 6;
  // Serial timer unit is 1 ms; minimum automatic period is 10 ms.
  localparam int TIMER_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam logic [15:0] TICK_CYCLES = 16'(TIMER_UNIT_NS / CLK_PERIOD_NS);
  localparam logic [13:0] TIMER_MIN_MS = 14'h000A;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
endpackage
